/* File: rtl/cpu_bus_device.sv */
// processor end: machine-cycle sequencer, refresh, interrupt entry
// user side issues one machine cycle per command; pins sync to mclk
`timescale 1ns/10ps
module cpu_bus_device (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  cpu_bus_if.dev                    bus,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  cpu_bus_pkg::cycle_kind_t  cmd_kind,
  input  wire logic [15:0]          cmd_addr,
  input  wire logic [7:0]           cmd_wdata,
  input  wire logic                 cmd_last,
  output logic                      rsp_valid,
  output logic [7:0]                rsp_data,
  input  wire logic                 irq_enable_set,
  input  wire logic                 irq_enable_clr,
  input  wire logic                 master_enable,
  input  wire logic [2:0]           restart_enable,
  input  wire logic [1:0]           irq_mode,
  input  wire logic                 vbase_wr,
  input  wire logic [7:0]           vbase_wdata,
  input  wire logic                 refresh_wr,
  input  wire logic [7:0]           refresh_wdata,
  input  wire logic                 pc_load,
  input  wire logic [15:0]          pc_wdata,
  output logic [15:0]               program_counter,
  output logic [7:0]                vector_base,
  output logic [7:0]                refresh_count,
  output logic                      irq_enable,
  output logic                      irq_taken,
  output logic [15:0]               irq_table_ptr,
  output logic                      power_saving
);

  typedef struct packed {
    cpu_bus_pkg::bus_state_t  st;
    logic                     phase;
    cpu_bus_pkg::cycle_kind_t kind;
    logic [15:0]              addr;
    logic [7:0]               wdata;
    logic                     last;
    logic                     reset_out;
    logic                     nmi_prev;
    logic                     nmi_latch;
    logic                     ie;
    logic [15:0]              pc;
    logic [7:0]               vbase;
    logic [7:0]               refresh;
    logic                     ack_pending;
    cpu_bus_pkg::irq_src_t    src;
    logic [1:0]               mode;
    logic [2:0]               ack_count;
    logic                     rsp_valid;
    logic [7:0]               rsp_data;
    logic                     taken;
    logic [15:0]              table_ptr;
  } dev_state_t;

  localparam dev_state_t RESET_STATE = '{
    st: cpu_bus_pkg::S_IDLE, kind: cpu_bus_pkg::CYC_INTERNAL,
    reset_out: 1'b1, nmi_prev: 1'b1, pc: cpu_bus_pkg::PC_RESET,
    vbase: cpu_bus_pkg::VBASE_RESET,
    refresh: cpu_bus_pkg::REFRESH_RESET, src: cpu_bus_pkg::SRC_NONE,
    default: '0};

  dev_state_t            s;
  dev_state_t            n;
  cpu_bus_pkg::irq_src_t sel;
  logic                  end_cycle;
  logic                  ack_ok;
  logic                  fetch_like;
  logic                  granted;

  // fetch-type cycles carry refresh and the second latch pulse
  function automatic logic is_fetch(cpu_bus_pkg::cycle_kind_t k);
    return k == cpu_bus_pkg::CYC_FETCH || k == cpu_bus_pkg::CYC_HALT ||
           k == cpu_bus_pkg::CYC_ACK;
  endfunction : is_fetch

  // data-in strobes; fetch-type ones end by t3, where refresh owns ad
  function automatic logic data_in(cpu_bus_pkg::bus_state_t st,
                                   cpu_bus_pkg::cycle_kind_t k,
                                   logic ackq);
    logic mid;
    mid = st == cpu_bus_pkg::S_T2 || st == cpu_bus_pkg::S_TW;
    return (k == cpu_bus_pkg::CYC_MEM_RD || k == cpu_bus_pkg::CYC_IO_RD) ?
           (mid || st == cpu_bus_pkg::S_T3) :
           (mid && is_fetch(k) && (k != cpu_bus_pkg::CYC_ACK || ackq));
  endfunction : data_in

  // restart target of each non-table source
  function automatic logic [15:0] vec_of(cpu_bus_pkg::irq_src_t v);
    case (v)
      cpu_bus_pkg::SRC_NMI:  vec_of = cpu_bus_pkg::VEC_NMI;
      cpu_bus_pkg::SRC_RESTART_IRQ_A: vec_of = cpu_bus_pkg::VEC_RESTART_IRQ_A;
      cpu_bus_pkg::SRC_RESTART_IRQ_B: vec_of = cpu_bus_pkg::VEC_RESTART_IRQ_B;
      cpu_bus_pkg::SRC_RESTART_IRQ_C: vec_of = cpu_bus_pkg::VEC_RESTART_IRQ_C;
      default:               vec_of = cpu_bus_pkg::VEC_MODE1;
    endcase
  endfunction : vec_of

  irq_priority u_prio (
    .nmi_pending           (s.nmi_latch),
    .restart_irq_a_n       (bus.restart_irq_a_n),
    .restart_irq_b_n       (bus.restart_irq_b_n),
    .restart_irq_c_n       (bus.restart_irq_c_n),
    .general_irq_request_n (bus.general_irq_request_n),
    .restart_enable        (restart_enable),
    .master_enable         (master_enable),
    .irq_enable            (s.ie),
    .sel                   (sel)
  );

  // strobe allowed only for mode 0/2 and within the byte budget
  assign ack_ok = s.src == cpu_bus_pkg::SRC_GENERAL_IRQ_REQUEST &&
                  s.mode != cpu_bus_pkg::IRQ_MODE1 &&
                  s.ack_count < ((s.mode == cpu_bus_pkg::IRQ_MODE2) ?
                  cpu_bus_pkg::MODE2_ACKS : cpu_bus_pkg::MODE0_ACKS);
  assign fetch_like = is_fetch(s.kind);
  assign granted = s.st == cpu_bus_pkg::S_GRANT;

  // next-state: one t-state per two mclk, moves on the second half
  always_comb begin
    n = s;
    end_cycle = 1'b0;
    n.phase = ~s.phase;
    n.reset_out = 1'b0;
    n.rsp_valid = 1'b0;
    n.taken = 1'b0;
    n.nmi_prev = bus.nmi_n;
    if (irq_enable_clr) n.ie = 1'b0;
    if (irq_enable_set) n.ie = 1'b1;
    if (vbase_wr) n.vbase = vbase_wdata;
    if (refresh_wr) n.refresh = refresh_wdata;
    if (pc_load) n.pc = pc_wdata;
    if (s.phase) begin
      case (s.st)
        cpu_bus_pkg::S_IDLE: begin
          if (!bus.bus_request_input_n) begin
            n.st = cpu_bus_pkg::S_GRANT;
          end else if (s.ack_pending) begin
            n.kind = cpu_bus_pkg::CYC_ACK;
            n.last = 1'b0;
            n.ack_pending = 1'b0;
            n.st = cpu_bus_pkg::S_T1;
          end else if (cmd_valid) begin
            n.kind = cmd_kind;
            n.addr = cmd_addr;
            n.wdata = cmd_wdata;
            n.last = cmd_last;
            n.st = cpu_bus_pkg::S_T1;
          end
        end
        cpu_bus_pkg::S_T1: n.st = cpu_bus_pkg::S_T2;
        cpu_bus_pkg::S_T2, cpu_bus_pkg::S_TW: begin
          // internal operations carry no strobe, so wait is ignored
          if (s.kind != cpu_bus_pkg::CYC_INTERNAL && !bus.wait_n)
            n.st = cpu_bus_pkg::S_TW;
          else
            n.st = cpu_bus_pkg::S_T3;
        end
        cpu_bus_pkg::S_T3: begin
          n.st = fetch_like ? cpu_bus_pkg::S_T4 : cpu_bus_pkg::S_IDLE;
          end_cycle = !fetch_like;
        end
        cpu_bus_pkg::S_T4: begin
          n.st = cpu_bus_pkg::S_IDLE;
          end_cycle = 1'b1;
        end
        cpu_bus_pkg::S_GRANT:
          if (bus.bus_request_input_n) n.st = cpu_bus_pkg::S_IDLE;
        cpu_bus_pkg::S_SAVE:
          if (bus.power_save_input_n) n.st = cpu_bus_pkg::S_IDLE;
        default: n.st = cpu_bus_pkg::S_IDLE;
      endcase
    end
    // capture on the rising edge of read or acknowledge
    if (data_in(s.st, s.kind, ack_ok) && !data_in(n.st, s.kind, ack_ok))
      n.rsp_data = bus.ad;
    if (end_cycle) begin
      n.rsp_valid = 1'b1;
      if (fetch_like) n.refresh = s.refresh + 8'h01;
      if (s.kind == cpu_bus_pkg::CYC_ACK && ack_ok) begin
        n.ack_count = s.ack_count + 3'h1;
        if (s.mode == cpu_bus_pkg::IRQ_MODE2)
          n.table_ptr = {s.vbase, n.rsp_data};
      end
      if (s.last) begin
        if (sel != cpu_bus_pkg::SRC_NONE) begin
          n.taken = 1'b1;
          n.ack_pending = 1'b1;
          n.src = sel;
          n.mode = irq_mode;
          n.ack_count = 3'h0;
          n.ie = 1'b0;
          if (sel == cpu_bus_pkg::SRC_NMI) n.nmi_latch = 1'b0;
          if (sel != cpu_bus_pkg::SRC_GENERAL_IRQ_REQUEST ||
              irq_mode == cpu_bus_pkg::IRQ_MODE1)
            n.pc = vec_of(sel);
        end else if (!bus.power_save_input_n) begin
          n.st = cpu_bus_pkg::S_SAVE;
        end
      end
      // request seen only once the machine cycle is complete
      if (!bus.bus_request_input_n) n.st = cpu_bus_pkg::S_GRANT;
    end
    // edge set placed last so it beats the acceptance clear
    if (s.nmi_prev && !bus.nmi_n) n.nmi_latch = 1'b1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) s <= RESET_STATE;
    else     s <= n;
  end

  // user-side handshake and visible state
  assign cmd_ready = s.phase && s.st == cpu_bus_pkg::S_IDLE &&
                     bus.bus_request_input_n && !s.ack_pending &&
                     !s.reset_out;
  assign rsp_valid = s.rsp_valid;
  assign rsp_data = s.rsp_data;
  assign program_counter = s.pc;
  assign vector_base = s.vbase;
  assign refresh_count = s.refresh;
  assign irq_enable = s.ie;
  assign irq_taken = s.taken;
  assign irq_table_ptr = s.table_ptr;
  assign power_saving = s.st == cpu_bus_pkg::S_SAVE;

  // pin drive; everything shared floats in reset and while granted
  always_comb begin
    logic t34;
    logic wr_k;
    t34 = s.st == cpu_bus_pkg::S_T3 || s.st == cpu_bus_pkg::S_T4;
    wr_k = s.kind == cpu_bus_pkg::CYC_MEM_WR ||
           s.kind == cpu_bus_pkg::CYC_IO_WR;
    bus.addr_hi_dev_oe = !s.reset_out && !granted;
    bus.ctl_oe = !s.reset_out && !granted;
    bus.io_mem = s.kind == cpu_bus_pkg::CYC_IO_RD ||
                 s.kind == cpu_bus_pkg::CYC_IO_WR;
    if (fetch_like && t34)
      bus.addr_hi_dev = s.vbase;
    else if (bus.io_mem)
      bus.addr_hi_dev = s.addr[7:0];
    else
      bus.addr_hi_dev = s.addr[15:8];
    bus.wr_n = !(wr_k && (s.st == cpu_bus_pkg::S_T2 ||
                 s.st == cpu_bus_pkg::S_TW || s.st == cpu_bus_pkg::S_T3));
    bus.ad_dev_oe = bus.ctl_oe && (s.st == cpu_bus_pkg::S_T1 ||
                    (fetch_like && t34) || !bus.wr_n);
    if (s.st == cpu_bus_pkg::S_T1)      bus.ad_dev = s.addr[7:0];
    else if (fetch_like && t34)         bus.ad_dev = s.refresh;
    else                                bus.ad_dev = s.wdata;
    // acknowledge cycle keeps the read strobe suppressed
    bus.rd_n = !(s.kind != cpu_bus_pkg::CYC_ACK &&
                 data_in(s.st, s.kind, 1'b0));
    bus.irq_acknowledge_strobe_n = !(s.kind == cpu_bus_pkg::CYC_ACK &&
      data_in(s.st, s.kind, ack_ok));
    bus.ale = !s.phase && (s.st == cpu_bus_pkg::S_T1 ||
              (fetch_like && s.st == cpu_bus_pkg::S_T3));
    bus.refresh_strobe_n = !(fetch_like && t34 && !granted);
    {bus.cycle_status_bit1, bus.cycle_status_bit0} =
      (s.kind == cpu_bus_pkg::CYC_HALT) ? cpu_bus_pkg::ST_HALT :
      wr_k ? cpu_bus_pkg::ST_WRITE :
      fetch_like ? cpu_bus_pkg::ST_FETCH : cpu_bus_pkg::ST_READ;
    bus.bus_grant_n = !granted;
    bus.reset_out = s.reset_out;
    bus.clk_out = s.phase;
  end

endmodule : cpu_bus_device

/* File: rtl/cpu_bus_host.sv */
// peripheral and alternate-master end of the processor bus
// user side supplies read and vector bytes; pins sync to mclk
`timescale 1ns/10ps
module cpu_bus_host (
  input  wire logic         mclk,
  input  wire logic         rst,
  cpu_bus_if.host           bus,
  input  wire logic [7:0]   rd_value,
  input  wire logic [7:0]   ack_value,
  input  wire logic         wait_req,
  input  wire logic         take_bus,
  input  wire logic [15:0]  master_addr,
  input  wire logic [7:0]   master_data,
  input  wire logic         nmi_req,
  input  wire logic [2:0]   restart_req,
  input  wire logic         general_irq_request_req,
  input  wire logic         save_req,
  output logic              bus_owned,
  output logic              addr_valid,
  output logic [15:0]       latched_addr,
  output logic              wr_seen,
  output logic [7:0]        wr_data
);

  typedef struct packed {
    logic        ale_prev;
    logic        wr_prev;
    logic [15:0] laddr;
    logic        avalid;
    logic [7:0]  wbuf;
    logic [7:0]  wdata;
    logic        wseen;
    logic [7:0]  rd_byte;
    logic [7:0]  ack_byte;
  } host_state_t;

  host_state_t s;
  host_state_t n;

  // latch address on the strobe fall, write data while strobe low
  always_comb begin
    n = s;
    n.ale_prev = bus.ale;
    n.wr_prev = bus.wr_line_n;
    n.avalid = 1'b0;
    n.wseen = 1'b0;
    n.rd_byte = rd_value;
    n.ack_byte = {ack_value[7:1], 1'b0};
    if (s.ale_prev && !bus.ale) begin
      n.laddr = {bus.addr_hi, bus.ad};
      n.avalid = 1'b1;
    end
    if (!bus.wr_line_n) n.wbuf = bus.ad;
    if (!s.wr_prev && bus.wr_line_n) begin
      n.wdata = s.wbuf;
      n.wseen = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) s <= '{ale_prev: 1'b0, wr_prev: 1'b1, default: '0};
    else     s <= n;
  end

  // drive data only in our strobe window, or once granted
  always_comb begin
    logic own;
    own = take_bus && !bus.bus_grant_n;
    bus.bus_request_input_n = !take_bus;
    bus.addr_hi_host_oe = own;
    bus.addr_hi_host = master_addr[15:8];
    bus.ad_host_oe = own || !bus.rd_line_n ||
                     !bus.irq_acknowledge_strobe_n;
    if (own)
      bus.ad_host = master_data;
    else if (!bus.irq_acknowledge_strobe_n)
      bus.ad_host = s.ack_byte;
    else
      bus.ad_host = s.rd_byte;
    // user raises wait ahead of any write strobe it wants to stall
    bus.wait_n = !wait_req;
    bus.nmi_n = !nmi_req;
    bus.restart_irq_a_n = !restart_req[0];
    bus.restart_irq_b_n = !restart_req[1];
    bus.restart_irq_c_n = !restart_req[2];
    bus.general_irq_request_n = !general_irq_request_req;
    bus.power_save_input_n = !save_req;
    bus_owned = own;
  end

  assign addr_valid = s.avalid;
  assign latched_addr = s.laddr;
  assign wr_seen = s.wseen;
  assign wr_data = s.wdata;

endmodule : cpu_bus_host

/* File: rtl/cpu_bus_if.sv */
// pin bundle between the processor end and its peripherals
// undriven shared lines resolve high as if pulled up
`timescale 1ns/10ps
interface cpu_bus_if;
  logic [7:0] addr_hi_dev;
  logic       addr_hi_dev_oe;
  logic [7:0] addr_hi_host;
  logic       addr_hi_host_oe;
  logic [7:0] addr_hi;
  logic [7:0] ad_dev;
  logic       ad_dev_oe;
  logic [7:0] ad_host;
  logic       ad_host_oe;
  logic [7:0] ad;
  logic       io_mem;
  logic       rd_n;
  logic       wr_n;
  logic       ctl_oe;
  logic       io_mem_line;
  logic       rd_line_n;
  logic       wr_line_n;
  logic       ale;
  logic       refresh_strobe_n;
  logic       cycle_status_bit0;
  logic       cycle_status_bit1;
  logic       irq_acknowledge_strobe_n;
  logic       wait_n;
  logic       bus_request_input_n;
  logic       bus_grant_n;
  logic       nmi_n;
  logic       restart_irq_a_n;
  logic       restart_irq_b_n;
  logic       restart_irq_c_n;
  logic       general_irq_request_n;
  logic       power_save_input_n;
  logic       reset_out;
  logic       clk_out;

  // wire resolution from the enables
  assign addr_hi = addr_hi_dev_oe ? addr_hi_dev :
                   addr_hi_host_oe ? addr_hi_host : 8'hFF;
  assign ad = ad_dev_oe ? ad_dev : ad_host_oe ? ad_host : 8'hFF;
  assign io_mem_line = ctl_oe ? io_mem : 1'b1;
  assign rd_line_n = ctl_oe ? rd_n : 1'b1;
  assign wr_line_n = ctl_oe ? wr_n : 1'b1;

  modport dev (
    output addr_hi_dev, addr_hi_dev_oe, ad_dev, ad_dev_oe, io_mem,
    output rd_n, wr_n, ctl_oe, ale, refresh_strobe_n,
    output cycle_status_bit0, cycle_status_bit1,
    output irq_acknowledge_strobe_n, bus_grant_n, reset_out, clk_out,
    input  ad, wait_n, bus_request_input_n, nmi_n, restart_irq_a_n,
    input  restart_irq_b_n, restart_irq_c_n, general_irq_request_n,
    input  power_save_input_n
  );

  modport host (
    output addr_hi_host, addr_hi_host_oe, ad_host, ad_host_oe,
    output wait_n, bus_request_input_n, nmi_n, restart_irq_a_n,
    output restart_irq_b_n, restart_irq_c_n, general_irq_request_n,
    output power_save_input_n,
    input  addr_hi, ad, io_mem_line, rd_line_n, wr_line_n, ale,
    input  refresh_strobe_n, cycle_status_bit0, cycle_status_bit1,
    input  irq_acknowledge_strobe_n, bus_grant_n, reset_out, clk_out
  );
endinterface : cpu_bus_if

/* File: rtl/cpu_bus_pkg.sv */
// constants, state codes and cycle kinds used by the processor end and the bench
// assumes a single mclk domain; t-states last two mclk periods
// Function
// - reset floats bus, clears pointers, disables interrupts
// - grant only after cycle ends; master waits
// - refresh strobe stays high while bus granted
// - nmi falling edge latched, vectors to 0066
// - enabled restarts vector to 003C, 0034, 002C
// - fixed priority nmi, a, b, c, general
// - general request needs both enables, three modes
// - mode 1: no acknowledge, jump to 0038
// - mode 0: one to four acknowledge bytes
// - mode 2: single acknowledge carries vector low byte
// - mode 2 pointer: vector base plus even byte
// - acknowledge in fetch-type cycle after acceptance
// - low wait inserts whole wait states
// - wait honoured only in strobed or acknowledge cycles
// - power save sampled at instruction end halts
// - io cycles mirror port address on upper lines
// - reset output high while held in reset
// - io-memory select high for io, floats granted
// - refresh low t3-t4, counter and vector base
// - refresh counter increments after every opcode fetch
// - latch strobe in t1, and t3 of fetch
// - read captured on strobe rise; write data held
// - clock output is half the input rate
// - status 11 fetch/ack, 10 read, 01 write, 00 halt
package cpu_bus_pkg;

  // restart targets
  localparam logic [15:0] VEC_NMI       = 16'h0066;
  localparam logic [15:0] VEC_RESTART_IRQ_A      = 16'h003C;
  localparam logic [15:0] VEC_RESTART_IRQ_B      = 16'h0034;
  localparam logic [15:0] VEC_RESTART_IRQ_C      = 16'h002C;
  localparam logic [15:0] VEC_MODE1     = 16'h0038;

  // reset values
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [7:0]  VBASE_RESET   = 8'h00;
  localparam logic [7:0]  REFRESH_RESET = 8'h00;

  // status as {bit1, bit0}
  localparam logic [1:0]  ST_FETCH      = 2'h3;
  localparam logic [1:0]  ST_READ       = 2'h2;
  localparam logic [1:0]  ST_WRITE      = 2'h1;
  localparam logic [1:0]  ST_HALT       = 2'h0;

  // general request response modes
  localparam logic [1:0]  IRQ_MODE0     = 2'h0;
  localparam logic [1:0]  IRQ_MODE1     = 2'h1;
  localparam logic [1:0]  IRQ_MODE2     = 2'h2;
  localparam logic [2:0]  MODE0_ACKS    = 3'h4;
  localparam logic [2:0]  MODE2_ACKS    = 3'h1;

  typedef enum logic [2:0] {
    CYC_FETCH, CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD,
    CYC_IO_WR, CYC_INTERNAL, CYC_HALT, CYC_ACK
  } cycle_kind_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_NMI, SRC_RESTART_IRQ_A, SRC_RESTART_IRQ_B, SRC_RESTART_IRQ_C, SRC_GENERAL_IRQ_REQUEST
  } irq_src_t;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_T1    = 8'h02,
    S_T2    = 8'h04,
    S_TW    = 8'h08,
    S_T3    = 8'h10,
    S_T4    = 8'h20,
    S_GRANT = 8'h40,
    S_SAVE  = 8'h80
  } bus_state_t;

endpackage : cpu_bus_pkg

/* File: rtl/irq_priority.sv */
// fixed-priority pick among the five interrupt sources
// purely combinational; enables come from the processor end
`timescale 1ns/10ps
module irq_priority (
  input  wire logic                nmi_pending,
  input  wire logic                restart_irq_a_n,
  input  wire logic                restart_irq_b_n,
  input  wire logic                restart_irq_c_n,
  input  wire logic                general_irq_request_n,
  input  wire logic [2:0]          restart_enable,
  input  wire logic                master_enable,
  input  wire logic                irq_enable,
  output cpu_bus_pkg::irq_src_t    sel
);

  // nmi ignores every enable; the rest need the master enable
  always_comb begin
    sel = cpu_bus_pkg::SRC_NONE;
    if (nmi_pending)
      sel = cpu_bus_pkg::SRC_NMI;
    else if (master_enable && restart_enable[0] && !restart_irq_a_n)
      sel = cpu_bus_pkg::SRC_RESTART_IRQ_A;
    else if (master_enable && restart_enable[1] && !restart_irq_b_n)
      sel = cpu_bus_pkg::SRC_RESTART_IRQ_B;
    else if (master_enable && restart_enable[2] && !restart_irq_c_n)
      sel = cpu_bus_pkg::SRC_RESTART_IRQ_C;
    else if (master_enable && irq_enable && !general_irq_request_n)
      sel = cpu_bus_pkg::SRC_GENERAL_IRQ_REQUEST;
  end

endmodule : irq_priority

/* File: tb/cpu_bus_properties.sv */
// pin-level properties of the processor bus, one mclk domain
// fed from the interface signals beside the two joined ends
`timescale 1ns/10ps
module cpu_bus_properties (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       addr_hi_dev_oe,
  input wire logic       ad_dev_oe,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] ad,
  input wire logic       ctl_oe,
  input wire logic       io_mem,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       ale,
  input wire logic       refresh_strobe_n,
  input wire logic       cycle_status_bit0,
  input wire logic       cycle_status_bit1,
  input wire logic       irq_acknowledge_strobe_n,
  input wire logic       bus_grant_n,
  input wire logic       reset_out,
  input wire logic       clk_out
);
  // status pair in {bit1, bit0} order, as the package codes it
  wire logic [1:0] st = {cycle_status_bit1, cycle_status_bit0};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_grant_floats: assert property (!bus_grant_n |->
    !ctl_oe && !ad_dev_oe && !addr_hi_dev_oe) else $error("bus driven");
  a_grant_refresh: assert property (!bus_grant_n |->
    refresh_strobe_n) else $error("refresh during grant");
  a_refresh_fetch: assert property (!refresh_strobe_n |->
    st[1] == st[0] && rd_n && wr_n) else $error("refresh cycle");
  a_io_mirror: assert property ($fell(ale) && ctl_oe && io_mem |->
    addr_hi == ad) else $error("port byte not mirrored");
  a_write_drive: assert property (!wr_n && ctl_oe |->
    ad_dev_oe && st == cpu_bus_pkg::ST_WRITE) else $error("write data");
  a_read_float: assert property (!rd_n && ctl_oe |->
    !ad_dev_oe && st != cpu_bus_pkg::ST_WRITE) else $error("read float");
  a_ack_status: assert property (!irq_acknowledge_strobe_n |->
    st == cpu_bus_pkg::ST_FETCH && rd_n) else $error("ack status");
  a_clock_half: assert property (!reset_out && !$past(reset_out) |->
    clk_out != $past(clk_out)) else $error("clock output rate");
endmodule : cpu_bus_properties

/* File: tb/testbench.sv */
// self-checking bench: processor end and peripheral end joined
// single mclk domain; stimulus changes on the falling edge
`timescale 1ns/10ps
module testbench;
  logic mclk, rst, cmd_valid, cmd_last, irq_enable_set, irq_enable_clr;
  logic master_enable, vbase_wr, refresh_wr, pc_load, wait_req, take_bus;
  logic nmi_req, general_irq_request_req, save_req, cmd_ready, rsp_valid, irq_enable;
  logic irq_taken, power_saving, bus_owned, addr_valid, wr_seen;
  logic [1:0] irq_mode;
  logic [2:0] restart_enable, restart_req;
  logic [7:0] cmd_wdata, vbase_wdata, refresh_wdata, rsp_data, vector_base;
  logic [7:0] refresh_count, rd_value, ack_value, master_data, wr_data;
  logic [15:0] cmd_addr, pc_wdata, program_counter, irq_table_ptr;
  logic [15:0] master_addr, latched_addr;
  cpu_bus_pkg::cycle_kind_t cmd_kind;
  int fail_count, tests_run, cycles, n0, n1;
  cpu_bus_if bus ();
  cpu_bus_device i_cpu_bus_device (.*);
  cpu_bus_host i_cpu_bus_host (.*);
  cpu_bus_properties i_cpu_bus_properties (.mclk, .rst,
    .addr_hi_dev_oe(bus.addr_hi_dev_oe), .ad_dev_oe(bus.ad_dev_oe),
    .addr_hi(bus.addr_hi), .ad(bus.ad), .ctl_oe(bus.ctl_oe),
    .io_mem(bus.io_mem), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .ale(bus.ale),
    .refresh_strobe_n(bus.refresh_strobe_n), .reset_out(bus.reset_out),
    .cycle_status_bit0(bus.cycle_status_bit0), .clk_out(bus.clk_out),
    .cycle_status_bit1(bus.cycle_status_bit1), .bus_grant_n(bus.bus_grant_n),
    .irq_acknowledge_strobe_n(bus.irq_acknowledge_strobe_n));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, well past the run's length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("ERROR %0t: %s wrong", $time, what);
    end
  endtask : chk
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // falling edges until the end-of-cycle pulse, bounded
  task automatic wait_rsp(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (rsp_valid !== 1'h1 && n < 99);
    chk(n < 99, "response");
  endtask : wait_rsp
  // offer one machine cycle, hold it until taken, then await its end
  task automatic cyc(input cpu_bus_pkg::cycle_kind_t k,
                     input logic [15:0] a, input logic l, output int n);
    @(negedge mclk);
    cmd_kind = k;
    {cmd_addr, cmd_last, cmd_valid} = {a, l, 1'h1};
    for (n = 0; cmd_ready !== 1'h1 && n < 99; n++) @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'h0;
    wait_rsp(n);
  endtask : cyc
  task automatic t_reset();
    repeat (16) @(negedge mclk);
    chk(bus.reset_out === 1'h1 && bus.ad_dev_oe === 1'h0, "reset pins");
    rst = 1'h0;
    repeat (3) @(negedge mclk);
    chk(bus.reset_out === 1'h0, "reset out");
    chk({program_counter, vector_base, refresh_count, irq_enable} === 33'h0,
        "cleared state");
  endtask : t_reset
  // write, fetch with refresh, io read, then a memory read stretched by wait
  task automatic t_rw();
    {rd_value, cmd_wdata, vbase_wdata, vbase_wr} = {24'h5A3C12, 1'h1};
    @(negedge mclk);
    vbase_wr = 1'h0;
    cyc(cpu_bus_pkg::CYC_MEM_WR, 16'hA55A, 1'h0, n0);
    @(negedge mclk);
    chk(wr_seen && wr_data === 8'h3C && latched_addr === 16'hA55A,
        "write");
    cyc(cpu_bus_pkg::CYC_FETCH, 16'h0100, 1'h0, n0);
    chk(refresh_count === 8'h01 && latched_addr[15:8] === 8'h12, "refresh");
    cyc(cpu_bus_pkg::CYC_IO_RD, 16'h0077, 1'h0, n0);
    chk(rsp_data === 8'h5A && latched_addr === 16'h7777, "io read");
    wait_req = 1'h1;
    fork
      cyc(cpu_bus_pkg::CYC_MEM_RD, 16'h0078, 1'h0, n1);
      begin
        repeat (14) @(negedge mclk);
        wait_req = 1'h0;
      end
    join
    chk(n1 > n0 && (n1 - n0) % 2 == 0, "wait states");
  endtask : t_rw
  task automatic t_grant();
    {master_addr, master_data, take_bus} = {16'hBEEF, 8'h99, 1'h1};
    for (int i = 0; i < 30 && bus_owned !== 1'h1; i++) @(negedge mclk);
    chk(bus_owned === 1'h1 && bus.refresh_strobe_n === 1'h1, "grant");
    chk(bus.addr_hi === 8'hBE && bus.rd_line_n === 1'h1, "float");
    take_bus = 1'h0;
    for (int i = 0; i < 30 && bus.bus_grant_n !== 1'h1; i++) @(negedge mclk);
    chk(bus.bus_grant_n === 1'h1, "release");
  endtask : t_grant
  // priority ladder, modes 1, 2, 0, and a restart with master off
  task automatic t_irq();
    logic [4:0] req [8] = '{5'h1F, 5'h0F, 5'h07, 5'h03, 5'h01, 5'h01,
                            5'h01, 5'h08};
    logic [15:0] vec [5] = '{cpu_bus_pkg::VEC_NMI, cpu_bus_pkg::VEC_RESTART_IRQ_A,
      cpu_bus_pkg::VEC_RESTART_IRQ_B, cpu_bus_pkg::VEC_RESTART_IRQ_C, cpu_bus_pkg::VEC_MODE1};
    {ack_value, restart_enable} = {8'hC6, 3'h7};
    for (int i = 0; i < 8; i++) begin
      irq_mode = (i == 5) ? 2'h2 : (i == 6) ? 2'h0 : 2'h1;
      {master_enable, irq_enable_set} = {i != 7, 1'h1};
      {nmi_req, restart_req, general_irq_request_req} = {req[i][4], req[i][1], req[i][2],
                                          req[i][3], req[i][0]};
      @(negedge mclk);
      {irq_enable_set, nmi_req} = 2'h0;
      cyc(cpu_bus_pkg::CYC_FETCH, 16'h0300, 1'h1, n0);
      chk(irq_taken === (i < 7), "acceptance");
      {restart_req, general_irq_request_req} = 4'h0;
      if (i < 7) wait_rsp(n0);
      if (i < 5) chk(program_counter === vec[i], "vector");
      if (i == 5) chk(irq_table_ptr === 16'h12C6, "table");
      if (i == 6) chk(rsp_data === 8'hC6, "mode 0 byte");
    end
  endtask : t_irq
  task automatic t_save();
    save_req = 1'h1;
    cyc(cpu_bus_pkg::CYC_HALT, 16'h0400, 1'h1, n0);
    for (int i = 0; i < 20 && power_saving !== 1'h1; i++) @(negedge mclk);
    chk(power_saving === 1'h1 && cmd_ready === 1'h0, "halt");
    save_req = 1'h0;
    for (int i = 0; i < 20 && power_saving !== 1'h0; i++) @(negedge mclk);
    chk(power_saving === 1'h0, "resume");
  endtask : t_save
  initial begin
    rst = 1'h1;
    cmd_kind = cpu_bus_pkg::CYC_FETCH;
    {cmd_valid, cmd_last, irq_enable_set, irq_enable_clr, master_enable,
     vbase_wr, refresh_wr, pc_load, wait_req, take_bus, nmi_req, general_irq_request_req,
     save_req, irq_mode, restart_enable, restart_req, cmd_wdata, vbase_wdata,
     refresh_wdata, cmd_addr, pc_wdata, master_addr, master_data, rd_value,
     ack_value} = '0;
    t_reset();
    t_rw();
    t_grant();
    t_irq();
    t_save();
    report_and_stop();
  end
endmodule : testbench
